// [rtl/tcbc_regs.sv]
`timescale 1ns/1ps
// Transfer count and drive bus control register bank
module tcbc_regs (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // External data space access from the MCU
  input wire logic [15:0] xaddr_i,
  input wire logic [7:0] xwdata_i,
  input wire logic xwr_i,
  input wire logic xrd_i,
  output logic [7:0] xrdata_o,
  // Bits held in the interface configuration registers
  input wire logic count_set_read_select_i,
  input wire logic drive_hard_reset_ctl_i,
  input wire logic auto_full_i,
  input wire logic auto_semi_i,
  input wire logic atapi_mode_i,
  input wire logic pio_mode_i,
  // Data movement on each side
  input wire logic usb_xfer_i,
  input wire logic [1:0] usb_xfer_bytes_i,
  input wire logic drive_xfer_i,
  input wire logic [1:0] drive_xfer_bytes_i,
  // Counts
  output logic [31:0] usb_count_o,
  output logic [31:0] drive_count_o,
  output logic [8:0] pio_sector_counter_o,
  // Automatic command fetch window
  output logic [4:0] packet_byte_length_o,
  output logic [3:0] fetch_first_task_o,
  output logic [4:0] fetch_task_count_o,
  output logic transaction_abort_done_o,
  // Drive bus output enables, low while driving, and the drive reset pin value
  output logic drive_bus_oe_n_o,
  output logic drive_reset_out_o,
  output logic drive_reset_oe_n_o
);
  import tcbc_pkg::*;

  // Counter sets
  logic [3:0] lane_hit;
  logic [3:0] count_we;
  logic [31:0] usb_count;
  logic [31:0] drive_count;
  logic [31:0] load_view;

  // Control register
  logic [4:0] len_r;
  logic [4:0] len_nxt;
  logic bus_off_r;
  logic bus_off_nxt;
  logic done_r;
  logic done_nxt;
  logic ctrl_hit;

  // Sector tracking
  logic [8:0] sector_r;
  logic [8:0] sector_nxt;
  logic [9:0] in_sector_r;
  logic [9:0] in_sector_nxt;
  logic [9:0] step;
  logic [9:0] sum;
  logic [31:0] drive_amt;

  // Read data
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [31:0] read_view;

  // Output registers
  logic [31:0] usb_count_r;
  logic [31:0] drive_count_r;
  logic [31:0] usb_count_nxt;
  logic [31:0] drive_count_nxt;
  logic [4:0] fetch_len_r;
  logic [4:0] fetch_len_nxt;
  logic [3:0] fetch_first_r;
  logic [3:0] fetch_first_nxt;
  logic abort_r;
  logic abort_nxt;
  logic bus_oe_n_r;
  logic bus_oe_n_nxt;
  logic rst_out_r;
  logic rst_out_nxt;
  logic rst_oe_n_r;
  logic rst_oe_n_nxt;

  // Address decode
  always_comb begin
    lane_hit = tcbc_count_lane(xaddr_i);
    ctrl_hit = (xaddr_i == TCBC_ADDR_CTRL);
    count_we = xwr_i ? lane_hit : 4'h0;
  end

  tcbc_down_counter u_usb_count (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .byte_we_i(count_we),
    .wdata_i(xwdata_i),
    .dec_i(usb_xfer_i),
    .dec_amt_i(usb_xfer_bytes_i),
    .count_o(usb_count)
  );

  // Drive side set counts only drive data
  tcbc_down_counter u_drive_count (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .byte_we_i(count_we),
    .wdata_i(xwdata_i),
    .dec_i(drive_xfer_i),
    .dec_amt_i(drive_xfer_bytes_i),
    .count_o(drive_count)
  );

  // Control register next value; bit 7 is reserved and never stored
  always_comb begin
    len_nxt = len_r;
    bus_off_nxt = bus_off_r;
    done_nxt = done_r;
    if (xwr_i && ctrl_hit) begin
      len_nxt = xwdata_i[TCBC_LEN_MSB:TCBC_LEN_LSB];
      bus_off_nxt = xwdata_i[TCBC_BUS_OFF_BIT];
      done_nxt = xwdata_i[TCBC_DONE_BIT];
    end
  end

  // Control register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      len_r <= TCBC_CTRL_RST[TCBC_LEN_MSB:TCBC_LEN_LSB];
      bus_off_r <= TCBC_CTRL_RST[TCBC_BUS_OFF_BIT];
      done_r <= TCBC_CTRL_RST[TCBC_DONE_BIT];
    end else begin
      len_r <= len_nxt;
      bus_off_r <= bus_off_nxt;
      done_r <= done_nxt;
    end
  end

  // Value the sector seed sees: current drive count with this write merged
  always_comb begin
    load_view = drive_count;
    for (int i = 0; i < 4; i++) begin
      if (count_we[i]) begin
        load_view[i*8 +: 8] = xwdata_i;
      end
    end
  end

  // Bytes really taken off the drive set; a step cut short at zero counts short
  always_comb begin
    drive_amt = {30'h0000_0000, drive_xfer_bytes_i};
    if (drive_count > drive_amt) begin
      step = {8'h00, drive_xfer_bytes_i};
    end else begin
      step = drive_count[9:0];
    end
  end

  // Sector counter: reseeded on any count write, counts whole sectors
  always_comb begin
    sum = in_sector_r + step;
    sector_nxt = sector_r;
    in_sector_nxt = in_sector_r;
    if (count_we != 4'h0) begin
      sector_nxt = load_view[TCBC_SECT_MSB:TCBC_SECT_LSB];
      in_sector_nxt = 10'h000;
    end else if (drive_xfer_i && pio_mode_i) begin
      if (sum >= TCBC_SECTOR_BYTES) begin
        in_sector_nxt = sum - TCBC_SECTOR_BYTES;
        if (sector_r != TCBC_SECTOR_RST) begin
          sector_nxt = sector_r - 9'h001;
        end
      end else begin
        in_sector_nxt = sum;
      end
    end
  end

  // Sector registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sector_r <= TCBC_SECTOR_RST;
      in_sector_r <= 10'h000;
    end else begin
      sector_r <= sector_nxt;
      in_sector_r <= in_sector_nxt;
    end
  end

  // Read data, captured on the read strobe; unmapped reads return zero
  always_comb begin
    read_view = count_set_read_select_i ? drive_count : usb_count;
    rdata_nxt = rdata_r;
    if (xrd_i) begin
      rdata_nxt = 8'h00;
      for (int i = 0; i < 4; i++) begin
        if (lane_hit[i]) begin
          rdata_nxt = read_view[i*8 +: 8];
        end
      end
      if (ctrl_hit) begin
        rdata_nxt[TCBC_LEN_MSB:TCBC_LEN_LSB] = len_r;
        rdata_nxt[TCBC_BUS_OFF_BIT] = bus_off_r;
        rdata_nxt[TCBC_DONE_BIT] = done_r;
        rdata_nxt[TCBC_RSV_BIT] = 1'b0;
      end
    end
  end

  // Command fetch window
  always_comb begin
    fetch_len_nxt = 5'h00;
    fetch_first_nxt = TCBC_ATAPI_FIRST_TASK;
    if (auto_full_i) begin
      if (atapi_mode_i) begin
        fetch_first_nxt = TCBC_ATAPI_FIRST_TASK;
        fetch_len_nxt = len_r;
      end else begin
        // Fixed task bytes 1 to 7
        fetch_first_nxt = TCBC_ATA_FIRST_TASK;
        fetch_len_nxt = TCBC_ATA_TASK_COUNT;
      end
    end
  end

  // Abort level towards the transaction machine
  always_comb begin
    // Done forces idle in automatic modes
    abort_nxt = done_r && (auto_full_i || auto_semi_i);
  end

  // Drive bus output enable
  always_comb begin
    bus_oe_n_nxt = bus_off_r;
  end

  // Drive reset pin value and enable
  always_comb begin
    if (drive_hard_reset_ctl_i) begin
      rst_out_nxt = 1'b0;
      rst_oe_n_nxt = 1'b0;
    end else begin
      rst_out_nxt = 1'b1;
      rst_oe_n_nxt = bus_off_r;
    end
  end

  // Registered copies of both sets; the count outputs lag the sets by one cycle
  always_comb begin
    usb_count_nxt = usb_count;
    drive_count_nxt = drive_count;
  end

  // Output registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= 8'h00;
      usb_count_r <= TCBC_COUNT_RST;
      drive_count_r <= TCBC_COUNT_RST;
      fetch_len_r <= 5'h00;
      fetch_first_r <= TCBC_ATAPI_FIRST_TASK;
      abort_r <= 1'b0;
      bus_oe_n_r <= 1'b1;
      rst_out_r <= 1'b1;
      rst_oe_n_r <= 1'b1;
    end else begin
      rdata_r <= rdata_nxt;
      usb_count_r <= usb_count_nxt;
      drive_count_r <= drive_count_nxt;
      fetch_len_r <= fetch_len_nxt;
      fetch_first_r <= fetch_first_nxt;
      abort_r <= abort_nxt;
      bus_oe_n_r <= bus_oe_n_nxt;
      rst_out_r <= rst_out_nxt;
      rst_oe_n_r <= rst_oe_n_nxt;
    end
  end

  assign xrdata_o = rdata_r;
  assign usb_count_o = usb_count_r;
  assign drive_count_o = drive_count_r;
  assign pio_sector_counter_o = sector_r;
  assign packet_byte_length_o = len_r;
  assign fetch_first_task_o = fetch_first_r;
  assign fetch_task_count_o = fetch_len_r;
  assign transaction_abort_done_o = abort_r;
  assign drive_bus_oe_n_o = bus_oe_n_r;
  assign drive_reset_out_o = rst_out_r;
  assign drive_reset_oe_n_o = rst_oe_n_r;

endmodule // tcbc_regs

// [rtl/tcbc_pkg.sv]
// Notes on behaviour
// - Two 32-bit count sets share four addresses
// - Byte write loads both sets at once
// - Read select input picks which set reads
// - Byte 0 lowest address, all zero at reset
// - Sets start at total, decrement to zero
// - Bits 17:9 seed the PIO sector counter
// - Sector counter decrements per 512 bytes
// - ATAPI auto packet: length bytes from task 0
// - ATA auto: task bytes 1 to 7, length ignored
// - Bus-off bit high tristates drive bus outputs
// - Bus-off bit touches output enables only
// - Hard reset drives reset pin low always
// - Done bit forces transaction machine idle in automatic modes
package tcbc_pkg;

  // Register byte addresses in the external data space
  localparam logic [15:0] TCBC_ADDR_COUNT_B0 = 16'hf0d6;
  localparam logic [15:0] TCBC_ADDR_COUNT_B1 = 16'hf0d7;
  localparam logic [15:0] TCBC_ADDR_COUNT_B2 = 16'hf0d8;
  localparam logic [15:0] TCBC_ADDR_COUNT_B3 = 16'hf0d9;
  localparam logic [15:0] TCBC_ADDR_CTRL = 16'hf0da;

  // Reset values
  localparam logic [31:0] TCBC_COUNT_RST = 32'h0000_0000;
  localparam logic [7:0] TCBC_CTRL_RST = 8'h20;
  localparam logic [8:0] TCBC_SECTOR_RST = 9'h000;

  // Control register field positions
  localparam int TCBC_LEN_LSB = 0;
  localparam int TCBC_LEN_MSB = 4;
  localparam int TCBC_BUS_OFF_BIT = 5;
  localparam int TCBC_DONE_BIT = 6;
  localparam int TCBC_RSV_BIT = 7;

  // Sector seed field inside the expected total
  localparam int TCBC_SECT_LSB = 9;
  localparam int TCBC_SECT_MSB = 17;

  // Sector size in bytes, 10 bits wide
  localparam logic [9:0] TCBC_SECTOR_BYTES = 10'h200;

  // Task-file window used by the automatic command fetch
  localparam logic [3:0] TCBC_ATAPI_FIRST_TASK = 4'h0;
  localparam logic [3:0] TCBC_ATA_FIRST_TASK = 4'h1;
  localparam logic [4:0] TCBC_ATA_TASK_COUNT = 5'h07;

  // One-hot byte-lane mask of a counter address, or none
  function automatic logic [3:0] tcbc_count_lane(input logic [15:0] addr);
    logic [3:0] lane;
    lane = 4'h0;
    case (addr)
      TCBC_ADDR_COUNT_B0: lane = 4'h1;
      TCBC_ADDR_COUNT_B1: lane = 4'h2;
      TCBC_ADDR_COUNT_B2: lane = 4'h4;
      TCBC_ADDR_COUNT_B3: lane = 4'h8;
      default: lane = 4'h0;
    endcase
    return lane;
  endfunction

endpackage

// [rtl/tcbc_down_counter.sv]
`timescale 1ns/1ps
// One 32-bit count set: byte loads from the bus, decrements from one side
module tcbc_down_counter (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] byte_we_i,
  input wire logic [7:0] wdata_i,
  input wire logic dec_i,
  input wire logic [1:0] dec_amt_i,
  output logic [31:0] count_o
);
  import tcbc_pkg::*;

  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [31:0] amt;

  // Load wins over decrement; decrement stops at zero
  always_comb begin
    amt = {30'h0000_0000, dec_amt_i};
    count_nxt = count_r;
    if (byte_we_i != 4'h0) begin
      for (int i = 0; i < 4; i++) begin
        if (byte_we_i[i]) begin
          count_nxt[i*8 +: 8] = wdata_i;
        end
      end
    end else if (dec_i) begin
      if (count_r > amt) begin
        count_nxt = count_r - amt;
      end else begin
        count_nxt = TCBC_COUNT_RST;
      end
    end
  end

  // Count register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_r <= TCBC_COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count_o = count_r;

endmodule // tcbc_down_counter

// [verif/tcbc_regs_monitor.sv]
`timescale 1ns/1ps
// Port checks for the transfer count register bank
module tcbc_regs_monitor (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [15:0] xaddr_i,
  input wire logic [7:0] xwdata_i,
  input wire logic xwr_i,
  input wire logic xrd_i,
  input wire logic [7:0] xrdata_o,
  input wire logic count_set_read_select_i,
  input wire logic drive_hard_reset_ctl_i,
  input wire logic auto_full_i,
  input wire logic auto_semi_i,
  input wire logic atapi_mode_i,
  input wire logic usb_xfer_i,
  input wire logic [1:0] usb_xfer_bytes_i,
  input wire logic drive_xfer_i,
  input wire logic [31:0] usb_count_o,
  input wire logic [31:0] drive_count_o,
  input wire logic [8:0] pio_sector_counter_o,
  input wire logic [4:0] packet_byte_length_o,
  input wire logic [3:0] fetch_first_task_o,
  input wire logic [4:0] fetch_task_count_o,
  input wire logic transaction_abort_done_o,
  input wire logic drive_bus_oe_n_o,
  input wire logic drive_reset_out_o,
  input wire logic drive_reset_oe_n_o
);
  import tcbc_pkg::*;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Count after a decrement that stops at zero
  function automatic logic [31:0] sub_sat(logic [31:0] c, logic [1:0] b);
    return (c > 32'(b)) ? c - 32'(b) : 32'h0;
  endfunction

  // Register bus and count sets
  AST_LOAD_BOTH: assert property (xwr_i && xaddr_i == TCBC_ADDR_COUNT_B0 |-> ##2
    usb_count_o[7:0] == $past(xwdata_i, 2) && drive_count_o[7:0] == $past(xwdata_i, 2))
    else $error("byte load missed a set");
  AST_READ_SEL: assert property (xrd_i && xaddr_i == TCBC_ADDR_COUNT_B1 |=>
    xrdata_o == ($past(count_set_read_select_i) ? drive_count_o[15:8] : usb_count_o[15:8]))
    else $error("read set select wrong");
  AST_USB_DEC: assert property (usb_xfer_i && !xwr_i |-> ##2
    usb_count_o == sub_sat($past(usb_count_o), $past(usb_xfer_bytes_i, 2)))
    else $error("usb count decrement wrong");
  AST_DRIVE_OWN: assert property (!drive_xfer_i && !xwr_i |-> ##2 $stable(drive_count_o))
    else $error("drive count moved without drive data");
  // Drive pin control
  AST_BUS_OFF: assert property (xwr_i && xaddr_i == TCBC_ADDR_CTRL |-> ##2
    drive_bus_oe_n_o == $past(xwdata_i[5], 2))
    else $error("bus enable does not follow bus-off bit");
  AST_DRIVE_HARD_RESET_CTL: assert property (drive_hard_reset_ctl_i |=>
    !drive_reset_out_o && !drive_reset_oe_n_o)
    else $error("reset pin not driven low");
  AST_RST_PIN_OE: assert property (!drive_hard_reset_ctl_i |=>
    drive_reset_out_o && drive_reset_oe_n_o == drive_bus_oe_n_o)
    else $error("reset pin enable wrong");
  AST_ABORT_MODE: assert property (transaction_abort_done_o |->
    $past(auto_full_i || auto_semi_i))
    else $error("abort outside automatic modes");
  // Automatic fetch window
  AST_FETCH_ATA: assert property (auto_full_i && !atapi_mode_i |=>
    fetch_first_task_o == TCBC_ATA_FIRST_TASK && fetch_task_count_o == TCBC_ATA_TASK_COUNT)
    else $error("ata fetch window wrong");
  // Fetch count takes the length held at the request edge, before any write lands
  AST_FETCH_PKT: assert property (auto_full_i && atapi_mode_i |=>
    fetch_first_task_o == TCBC_ATAPI_FIRST_TASK &&
    fetch_task_count_o == $past(packet_byte_length_o))
    else $error("packet fetch window wrong");

  // Main scenarios reached
  cover property (pio_sector_counter_o == 9'h0 && $past(pio_sector_counter_o) == 9'h1);
  cover property (!drive_reset_out_o);
  cover property (transaction_abort_done_o);
endmodule // tcbc_regs_monitor

bind tcbc_regs tcbc_regs_monitor u_mon (.*);

// [verif/tcbc_drive_model.sv]
`timescale 1ns/1ps
// Drive side: moves one 16-bit word per strobe, with random stalls
module tcbc_drive_model (
  input wire logic sys_clk_i,
  input wire logic go_i,
  output logic xfer_o = 1'b0,
  output logic [1:0] bytes_o = 2'h0
);
  int seed = 32'h00005a17;
  always @(negedge sys_clk_i) begin
    if (go_i && ($random(seed) % 4 != 0)) begin
      xfer_o <= 1'b1;
      bytes_o <= 2'h2;
    end else begin
      xfer_o <= 1'b0;
      bytes_o <= 2'($random(seed));
    end
  end
endmodule // tcbc_drive_model

// [verif/tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the transfer count register bank
module tb;
  import tcbc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [15:0] xaddr_i = 16'h0;
  logic [7:0] xwdata_i = 8'h0;
  logic xwr_i = 1'b0;
  logic xrd_i = 1'b0;
  logic count_set_read_select_i = 1'b0;
  logic drive_hard_reset_ctl_i = 1'b0;
  logic auto_full_i = 1'b0;
  logic auto_semi_i = 1'b0;
  logic atapi_mode_i = 1'b0;
  logic pio_mode_i = 1'b1;
  logic usb_xfer_i = 1'b0;
  logic [1:0] usb_xfer_bytes_i = 2'h0;
  logic drive_xfer_i, drive_go = 1'b0;
  logic [1:0] drive_xfer_bytes_i;
  logic [7:0] xrdata_o, rv;
  logic [31:0] usb_count_o, drive_count_o, v, eu;
  logic [8:0] pio_sector_counter_o;
  logic [4:0] packet_byte_length_o, fetch_task_count_o;
  logic [3:0] fetch_first_task_o;
  logic transaction_abort_done_o, drive_bus_oe_n_o, drive_reset_out_o, drive_reset_oe_n_o;
  int miscompares = 0;
  int comparisons = 0;
  int seed = 32'h040a30dc;

  tcbc_regs u_dut (.*);
  tcbc_drive_model u_drive (.sys_clk_i(sys_clk_i), .go_i(drive_go),
    .xfer_o(drive_xfer_i), .bytes_o(drive_xfer_bytes_i));

  // Clock
  always #2 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // One bus access, inputs moved at the falling edge
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(negedge sys_clk_i);
    xaddr_i = a;
    xwdata_i = d;
    xwr_i = w;
    xrd_i = !w;
    @(negedge sys_clk_i);
    xwr_i = 1'b0;
    xrd_i = 1'b0;
    rv = xrdata_o;
  endtask
  task automatic wcount(input logic [31:0] c);
    for (int i = 0; i < 4; i++) acc(TCBC_ADDR_COUNT_B0 + 16'(i), 1'b1, c[8*i+:8]);
    @(negedge sys_clk_i);
  endtask
  function automatic logic [31:0] sat(logic [31:0] c, logic [1:0] b);
    return (c > 32'(b)) ? c - 32'(b) : 32'h0;
  endfunction
  task automatic settle;
    repeat (3) @(negedge sys_clk_i);
  endtask
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    finish_test;
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rstn_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      acc(TCBC_ADDR_COUNT_B0 + 16'(i), 1'b0, 8'h0);
      chk("reset read", (i == 4) ? 32'h20 : 32'h0, 32'(rv));
    end
    chk("bus oe_n", 32'h1, 32'(drive_bus_oe_n_o));
    acc(TCBC_ADDR_CTRL, 1'b1, 8'h9f);
    acc(TCBC_ADDR_CTRL, 1'b0, 8'h0);
    chk("ctrl read", 32'h1f, 32'(rv));
    chk("length", 32'h1f, 32'(packet_byte_length_o));
    chk("bus oe_n", 32'h0, 32'(drive_bus_oe_n_o));
    auto_full_i = 1'b1;
    for (int m = 0; m < 2; m++) begin
      atapi_mode_i = m[0];
      settle;
      chk("first task", m ? 32'h0 : 32'h1, 32'(fetch_first_task_o));
      chk("task count", m ? 32'h1f : 32'h7, 32'(fetch_task_count_o));
    end
    acc(TCBC_ADDR_CTRL, 1'b1, 8'h60);
    for (int m = 0; m < 4; m++) begin
      {auto_full_i, auto_semi_i} = 2'(m);
      settle;
      chk("abort", 32'(m != 0), 32'(transaction_abort_done_o));
      drive_hard_reset_ctl_i = m[0];
      settle;
      chk("reset pin", 32'(!m[0]), 32'(drive_reset_out_o));
      chk("reset oe_n", 32'(!m[0]), 32'(drive_reset_oe_n_o));
      chk("bus oe_n", 32'h1, 32'(drive_bus_oe_n_o));
    end
    // Writing zero to the control register clears done and drops the abort level
    acc(TCBC_ADDR_CTRL, 1'b1, 8'h00);
    settle;
    chk("abort clear", 32'h0, 32'(transaction_abort_done_o));
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 32'hffff_ffff : 32'($random(seed));
      wcount(v);
      chk("usb count", v, usb_count_o);
      chk("drive count", v, drive_count_o);
      for (int s = 0; s < 8; s++) begin
        count_set_read_select_i = s[2];
        acc(TCBC_ADDR_COUNT_B0 + 16'(s[1:0]), 1'b0, 8'h0);
        chk("count read", 32'(v[8*s[1:0]+:8]), 32'(rv));
      end
    end
    wcount(32'h600);
    chk("sector seed", 32'h3, 32'(pio_sector_counter_o));
    eu = 32'h600;
    for (int i = 0; i < 700; i++) begin
      if (i == 40) chk("drive held", 32'h600, drive_count_o);
      usb_xfer_i = 1'b1;
      usb_xfer_bytes_i = (i < 40) ? 2'($random(seed)) : 2'h3;
      eu = sat(eu, usb_xfer_bytes_i);
      drive_go <= (i >= 40);
      @(negedge sys_clk_i);
    end
    usb_xfer_i = 1'b0;
    for (int i = 0; i < 4000 && drive_count_o !== 32'h0; i++) @(negedge sys_clk_i);
    drive_go <= 1'b0;
    settle;
    chk("usb drained", eu, usb_count_o);
    chk("drive drained", 32'h0, drive_count_o);
    chk("sectors", 32'h0, 32'(pio_sector_counter_o));
    // Sets apart: the USB side moves 300 bytes while the drive side waits
    wcount(32'h400);
    chk("sector seed", 32'h2, 32'(pio_sector_counter_o));
    usb_xfer_bytes_i = 2'h3;
    usb_xfer_i = 1'b1;
    repeat (100) @(negedge sys_clk_i);
    usb_xfer_i = 1'b0;
    settle;
    for (int s = 0; s < 4; s++) begin
      count_set_read_select_i = s[1];
      acc(TCBC_ADDR_COUNT_B0 + 16'(s[0]), 1'b0, 8'h0);
      v = s[1] ? 32'h400 : 32'h400 - 32'd300;
      chk("set select", 32'(v[8*s[0]+:8]), 32'(rv));
    end
    // Outside PIO the drive side moves data but no sector is counted
    pio_mode_i = 1'b0;
    drive_go <= 1'b1;
    repeat (500) @(negedge sys_clk_i);
    drive_go <= 1'b0;
    settle;
    chk("sectors held", 32'h2, 32'(pio_sector_counter_o));
    finish_test;
  end
endmodule // tb
